// File: inc/usart_params.svh
// Named constants for the serial transceiver: mode codes, counts, levels.
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH
`define MODE_HANDSHAKE 4'h2
`define MODE_SPI_MASTER 4'hE
`define MODE_SPI_SLAVE 4'hF
`define CLKSEL_DIV 2'h1
`define CLKSEL_EXT 2'h3
`define PRESCALE_LAST 3'h7
`define OS_LAST 4'hF
`define OS_MID 4'h7
`define OS_NONE 4'h0
`define CHAR_LEN_BASE 4'h5
`define CHAR_LEN_NINE 4'h9
`define DATA_BITS_MAX 4'h9
`define END_BRK_LAST 2'h1
`define LINE_IDLE 1'b1
`define DIV_ONE 16'h0001
`endif

// File: inc/usart_pkg.sv
// Types shared by the serial transceiver: states, configuration, state record.
package usart_pkg;

  // Receiver states for asynchronous and synchronous framing.
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_STOP  = 5'b01000,
    RX_BREAK = 5'b10000
  } rx_state_t;

  // Transmitter states for asynchronous and synchronous framing.
  typedef enum logic [5:0] {
    TX_IDLE   = 6'b000001,
    TX_START  = 6'b000010,
    TX_DATA   = 6'b000100,
    TX_PARITY = 6'b001000,
    TX_STOP   = 6'b010000,
    TX_BREAK  = 6'b100000
  } tx_state_t;

  // Shared shift engine states in the SPI modes.
  typedef enum logic [2:0] {
    SPI_IDLE  = 3'b001,
    SPI_LEAD  = 3'b010,
    SPI_TRAIL = 3'b100
  } spi_state_t;

  // Static configuration that software sets up before enabling the unit.
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] clock_source_select;
    logic clock_output_enable;
    logic [15:0] clock_divisor;
    logic [1:0] char_length_field;
    logic nine_bit_select;
    logic parity_enable;
    logic sync_mode;
  } usart_cfg_t;

  // Every flip-flop of the transceiver top except the pin synchroniser stages.
  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [15:0] baud_cnt;
    rx_state_t rx_st;
    logic [3:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic rx_zero;
    logic [1:0] rx_hi_cnt;
    logic [8:0] rx_data;
    logic rx_valid;
    logic rx_break_flag;
    logic frame_error;
    tx_state_t tx_st;
    logic [3:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [8:0] tx_shift;
    logic tx_par;
    logic brk_pend;
    logic txd;
    logic tx_ready;
    spi_state_t spi_st;
    logic [3:0] spi_bits;
    logic sck;
    logic sck_oe;
    logic rts;
    logic sck_prev;
    logic nss_prev;
  } usart_state_t;

endpackage

// File: logic/pin_sync.sv
// Two flip-flop synchroniser for a group of pins from outside the clock.
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // The first stage is only read by the second stage.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg; // Both stages.
  sync_state_t state_next; // Next value of both stages.

  // Shift the pins through the two stages.
  always_comb begin
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  // Reset to the idle level so no false edge is seen at release.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg.meta <= IDLE_LEVEL;
      state_reg.stable <= IDLE_LEVEL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule // pin_sync

// File: logic/usart_break_handshake_spi_mode.sv
// Serial transceiver core: break, RTS/CTS handshake and SPI modes.
//
// Overview of operation
// - Break is all-low character, no framing error.
// - Low stop of break sets flag; clear command clears.
// - End of break after high samples sets flag.
// - Mode value two enables handshake.
// - RTS high if receiver off or buffer full.
// - Enabled receiver drives RTS low.
// - Fresh DMA buffer drops full status, RTS low.
// - Transmitter honours CTS in handshake mode.
// - Mode fourteen: SPI master pin mapping.
// - Mode fifteen: SPI slave pin mapping.
// - SPI baud generator works as synchronous mode.
// - Slave clocks from SCK pin, ignores divisor.
// - Master clocks bits and drives slave select.
// - SPI frames have no framing bits, MSB first.
// - Length from length field or nine-bit select.
`include "usart_params.svh"

module usart_break_handshake_spi_mode (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire usart_pkg::usart_cfg_t cfg_i,
  input wire logic rx_enable_i,
  input wire logic tx_enable_i,
  input wire logic rx_soft_reset_i,
  input wire logic tx_soft_reset_i,
  input wire logic clear_status_cmd_i,
  input wire logic start_break_cmd_i,
  input wire logic stop_break_cmd_i,
  input wire logic rx_buffer_full_i,
  input wire logic [8:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [8:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_break_flag_o,
  output logic frame_error_o,
  input wire logic rxd_i,
  input wire logic cts_i,
  input wire logic sck_i,
  output logic txd_o,
  output logic rts_o,
  output logic sck_o,
  output logic sck_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and decoded configuration.

  usart_pkg::usart_state_t state_reg; // All flip-flops of this module but the pin synchroniser stages.
  usart_pkg::usart_state_t state_next; // Their next values.
  logic [2:0] pins_sync; // Synchronised {rxd, cts, sck}.
  logic rxd_s; // Receive line after synchronisation.
  logic cts_s; // CTS or slave select after synchronisation.
  logic sck_s; // SCK pin after synchronisation.
  logic spi_master; // SPI master mode selected.
  logic spi_slave; // SPI slave mode selected.
  logic spi_mode; // Either SPI mode.
  logic handshake; // Hardware handshaking selected.
  logic ext_clk; // SCK pin is the baud source.
  logic pre_en; // Prescaled peripheral clock enable.
  logic baud_wrap; // End of one divisor period.
  logic half_hit; // Middle of one divisor period.
  logic sck_rise; // Rising edge seen on the SCK pin.
  logic sck_fall; // Falling edge seen on the SCK pin.
  logic tick; // Sample or bit enable for the framed modes.
  logic [3:0] char_bits; // Data bits per character.
  logic [3:0] os_last; // Last sample index within one bit.
  logic [3:0] rx_total; // Data plus parity bits received.
  logic [8:0] tx_masked; // Transmit data cut to the character length.
  logic [8:0] tx_msb_aligned; // Transmit data with its MSB at bit 8.
  logic tx_accept; // A transmit word is taken this cycle.

  // All three pins idle high so reset shows no false edge.
  pin_sync #(
    .WIDTH(3),
    .IDLE_LEVEL(3'h7)
  ) u_pin_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({rxd_i, cts_i, sck_i}),
    .sync_o(pins_sync)
  );

  assign rxd_s = pins_sync[2];
  assign cts_s = pins_sync[1];
  assign sck_s = pins_sync[0];
  assign handshake = (cfg_i.mode == `MODE_HANDSHAKE);
  assign spi_master = (cfg_i.mode == `MODE_SPI_MASTER);
  assign spi_slave = (cfg_i.mode == `MODE_SPI_SLAVE);
  assign spi_mode = spi_master | spi_slave;
  // The slave never uses the divisor; the master must not pick SCK.
  assign ext_clk = (cfg_i.clock_source_select == `CLKSEL_EXT) & ~spi_master;
  // Nine-bit select overrides the length field.
  assign char_bits = cfg_i.nine_bit_select ? `CHAR_LEN_NINE :
    4'(`CHAR_LEN_BASE + {2'h0, cfg_i.char_length_field});
  // Asynchronous bits take sixteen samples; synchronous bits take one.
  assign os_last = cfg_i.sync_mode ? `OS_NONE : `OS_LAST;
  assign rx_total = 4'(char_bits + {3'h0, cfg_i.parity_enable});
  assign tx_masked = tx_data_i & 9'((9'h001 << char_bits) - 9'h001);
  assign tx_msb_aligned = 9'(tx_masked << (`DATA_BITS_MAX - char_bits));
  assign tx_accept = state_reg.tx_ready & tx_valid_i;

  ////////////////////////////////////////////////////////////////////////////
  // Baud rate generator, shared by framed and SPI master modes.

  // A divisor of zero stops the generator.
  assign pre_en = (cfg_i.clock_source_select != `CLKSEL_DIV) |
    (state_reg.pre_cnt == `PRESCALE_LAST);
  assign baud_wrap = pre_en & (cfg_i.clock_divisor != 16'h0000) &
    (state_reg.baud_cnt >= cfg_i.clock_divisor - `DIV_ONE);
  // Odd divisors give an uneven SCK; software keeps them even.
  assign half_hit = pre_en &
    (state_reg.baud_cnt == (cfg_i.clock_divisor >> 1) - `DIV_ONE);
  assign sck_rise = sck_s & ~state_reg.sck_prev;
  assign sck_fall = ~sck_s & state_reg.sck_prev;
  assign tick = ext_clk ? sck_rise : baud_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole transceiver.

  always_comb begin
    state_next = state_reg;
    state_next.rx_valid = 1'b0;
    state_next.sck_prev = sck_s;
    state_next.nss_prev = cts_s;
    // Generator counters.
    if (cfg_i.clock_source_select == `CLKSEL_DIV) begin
      state_next.pre_cnt = 3'(state_reg.pre_cnt + 3'h1);
    end else begin
      state_next.pre_cnt = 3'h0;
    end
    if (baud_wrap) begin
      state_next.baud_cnt = 16'h0000;
    end else if (pre_en) begin
      state_next.baud_cnt = 16'(state_reg.baud_cnt + 16'h0001);
    end
    // Clear first, so a set in the same cycle below wins.
    if (clear_status_cmd_i) begin
      state_next.rx_break_flag = 1'b0;
      state_next.frame_error = 1'b0;
    end
    // Break requests are remembered until the line can take them.
    if (start_break_cmd_i) begin
      state_next.brk_pend = 1'b1;
    end
    if (stop_break_cmd_i) begin
      state_next.brk_pend = 1'b0;
    end

    // Framed receiver; held idle in SPI modes or when disabled.
    if (spi_mode || !rx_enable_i || rx_soft_reset_i) begin
      state_next.rx_st = usart_pkg::RX_IDLE;
    end else if (tick) begin
      case (state_reg.rx_st)
        usart_pkg::RX_IDLE: begin
          if (!rxd_s) begin
            state_next.rx_bits = 4'h0;
            state_next.rx_shift = 9'h000;
            state_next.rx_zero = 1'b1;
            state_next.rx_cnt = cfg_i.sync_mode ? 4'h0 : 4'h1;
            state_next.rx_st = cfg_i.sync_mode ? usart_pkg::RX_DATA :
              usart_pkg::RX_START;
          end
        end
        usart_pkg::RX_START: begin
          // A start bit must still be low at mid-bit, else it was a glitch.
          if (state_reg.rx_cnt == `OS_MID) begin
            state_next.rx_cnt = 4'h0;
            state_next.rx_st = rxd_s ? usart_pkg::RX_IDLE :
              usart_pkg::RX_DATA;
          end else begin
            state_next.rx_cnt = 4'(state_reg.rx_cnt + 4'h1);
          end
        end
        usart_pkg::RX_DATA: begin
          if (state_reg.rx_cnt == os_last) begin
            state_next.rx_cnt = 4'h0;
            state_next.rx_zero = state_reg.rx_zero & ~rxd_s;
            if (state_reg.rx_bits < char_bits) begin
              state_next.rx_shift = {rxd_s, state_reg.rx_shift[8:1]};
            end
            state_next.rx_bits = 4'(state_reg.rx_bits + 4'h1);
            if (4'(state_reg.rx_bits + 4'h1) == rx_total) begin
              state_next.rx_st = usart_pkg::RX_STOP;
            end
          end else begin
            state_next.rx_cnt = 4'(state_reg.rx_cnt + 4'h1);
          end
        end
        usart_pkg::RX_STOP: begin
          if (state_reg.rx_cnt != os_last) begin
            state_next.rx_cnt = 4'(state_reg.rx_cnt + 4'h1);
          end else if (rxd_s) begin
            state_next.rx_data = 9'(state_reg.rx_shift >>
              (`DATA_BITS_MAX - char_bits));
            state_next.rx_valid = 1'b1;
            state_next.rx_st = usart_pkg::RX_IDLE;
          end else if (state_reg.rx_zero) begin
            // All-zero character with low stop: a break, not an error.
            state_next.rx_break_flag = 1'b1;
            state_next.rx_hi_cnt = 2'h0;
            state_next.rx_st = usart_pkg::RX_BREAK;
          end else begin
            state_next.frame_error = 1'b1;
            state_next.rx_st = usart_pkg::RX_IDLE;
          end
        end
        usart_pkg::RX_BREAK: begin
          // Two high sixteenths end the break; one sample when synchronous.
          if (!rxd_s) begin
            state_next.rx_hi_cnt = 2'h0;
          end else if (cfg_i.sync_mode ||
                       state_reg.rx_hi_cnt == `END_BRK_LAST) begin
            state_next.rx_break_flag = 1'b1;
            state_next.rx_st = usart_pkg::RX_IDLE;
          end else begin
            state_next.rx_hi_cnt = 2'(state_reg.rx_hi_cnt + 2'h1);
          end
        end
        default: begin
          state_next.rx_st = usart_pkg::RX_IDLE;
        end
      endcase
    end

    // Framed transmitter; held idle in SPI modes or on soft reset.
    if (spi_mode || tx_soft_reset_i) begin
      state_next.tx_st = usart_pkg::TX_IDLE;
      if (!spi_mode) begin
        state_next.txd = `LINE_IDLE;
        state_next.brk_pend = 1'b0;
      end
    end else begin
      case (state_reg.tx_st)
        usart_pkg::TX_IDLE: begin
          // Idle means the last character is out, so a break may start.
          if (state_reg.brk_pend) begin
            state_next.txd = 1'b0;
            state_next.brk_pend = 1'b0;
            state_next.tx_st = usart_pkg::TX_BREAK;
          end else if (tx_accept) begin
            state_next.tx_shift = tx_masked;
            state_next.tx_par = ^tx_masked;
            state_next.tx_bits = 4'h0;
            state_next.tx_cnt = 4'h0;
            state_next.txd = 1'b0;
            state_next.tx_st = usart_pkg::TX_START;
          end else begin
            state_next.txd = `LINE_IDLE;
          end
        end
        usart_pkg::TX_BREAK: begin
          if (stop_break_cmd_i) begin
            state_next.txd = `LINE_IDLE;
            state_next.tx_st = usart_pkg::TX_IDLE;
          end
        end
        default: begin
          if (tick) begin
            state_next.tx_cnt = (state_reg.tx_cnt == os_last) ? 4'h0 :
              4'(state_reg.tx_cnt + 4'h1);
          end
          if (tick && state_reg.tx_cnt == os_last) begin
            case (state_reg.tx_st)
              usart_pkg::TX_START: begin
                state_next.txd = state_reg.tx_shift[0];
                state_next.tx_st = usart_pkg::TX_DATA;
              end
              usart_pkg::TX_DATA: begin
                state_next.tx_bits = 4'(state_reg.tx_bits + 4'h1);
                state_next.tx_shift = {1'b0, state_reg.tx_shift[8:1]};
                if (4'(state_reg.tx_bits + 4'h1) != char_bits) begin
                  state_next.txd = state_reg.tx_shift[1];
                end else if (cfg_i.parity_enable) begin
                  state_next.txd = state_reg.tx_par;
                  state_next.tx_st = usart_pkg::TX_PARITY;
                end else begin
                  state_next.txd = `LINE_IDLE;
                  state_next.tx_st = usart_pkg::TX_STOP;
                end
              end
              usart_pkg::TX_PARITY: begin
                state_next.txd = `LINE_IDLE;
                state_next.tx_st = usart_pkg::TX_STOP;
              end
              default: begin
                state_next.tx_st = usart_pkg::TX_IDLE;
              end
            endcase
          end
        end
      endcase
    end

    // SPI shift engine: full duplex, MSB first, no framing bits.
    if (!spi_mode || tx_soft_reset_i || rx_soft_reset_i) begin
      state_next.spi_st = usart_pkg::SPI_IDLE;
    end else if (spi_master) begin
      case (state_reg.spi_st)
        usart_pkg::SPI_IDLE: begin
          state_next.sck = 1'b0;
          if (tx_accept) begin
            state_next.tx_shift = tx_msb_aligned;
            // Restart the generator so the first half bit is full length.
            // The read-back line then has time to cross the synchroniser.
            state_next.baud_cnt = 16'h0000;
            state_next.txd = tx_msb_aligned[8];
            state_next.rx_shift = 9'h000;
            state_next.spi_bits = 4'h0;
            state_next.spi_st = usart_pkg::SPI_LEAD;
          end
        end
        usart_pkg::SPI_LEAD: begin
          if (half_hit) begin
            state_next.sck = 1'b1;
            state_next.rx_shift = {state_reg.rx_shift[7:0], rxd_s};
            state_next.spi_st = usart_pkg::SPI_TRAIL;
          end
        end
        default: begin
          if (baud_wrap) begin
            state_next.sck = 1'b0;
            if (state_reg.spi_bits == 4'(char_bits - 4'h1)) begin
              state_next.rx_data = state_reg.rx_shift;
              state_next.rx_valid = 1'b1;
              state_next.spi_st = usart_pkg::SPI_IDLE;
            end else begin
              state_next.spi_bits = 4'(state_reg.spi_bits + 4'h1);
              state_next.tx_shift = {state_reg.tx_shift[7:0], 1'b0};
              state_next.txd = state_reg.tx_shift[7];
              state_next.spi_st = usart_pkg::SPI_LEAD;
            end
          end
        end
      endcase
    end else if (cts_s) begin
      // Slave deselected: abandon any partial character.
      state_next.spi_st = usart_pkg::SPI_IDLE;
    end else if (state_reg.spi_st == usart_pkg::SPI_IDLE) begin
      // The slave takes its word only when selected; absent data sends 0.
      if (state_reg.nss_prev) begin
        state_next.tx_shift = tx_accept ? tx_msb_aligned : 9'h000;
        state_next.txd = tx_accept ? tx_msb_aligned[8] : 1'b0;
        state_next.rx_shift = 9'h000;
        state_next.spi_bits = 4'h0;
        state_next.spi_st = usart_pkg::SPI_LEAD;
      end
    end else if (sck_rise) begin
      state_next.rx_shift = {state_reg.rx_shift[7:0], rxd_s};
      state_next.spi_st = usart_pkg::SPI_TRAIL;
    end else if (sck_fall && state_reg.spi_st == usart_pkg::SPI_TRAIL) begin
      state_next.tx_shift = {state_reg.tx_shift[7:0], 1'b0};
      state_next.txd = state_reg.tx_shift[7];
      state_next.spi_st = usart_pkg::SPI_LEAD;
      if (state_reg.spi_bits == 4'(char_bits - 4'h1)) begin
        state_next.rx_data = state_reg.rx_shift;
        state_next.rx_valid = 1'b1;
        state_next.spi_bits = 4'h0;
      end else begin
        state_next.spi_bits = 4'(state_reg.spi_bits + 4'h1);
      end
    end

    // Serial clock output: SPI master per bit, synchronous mode free.
    if (!spi_master) begin
      state_next.sck = (cfg_i.sync_mode && !ext_clk) ?
        (half_hit | (state_reg.sck & ~baud_wrap)) : 1'b0;
    end
    state_next.sck_oe = cfg_i.clock_output_enable & ~spi_slave & ~ext_clk;

    // RTS: flow control, slave select, or plain low otherwise.
    if (handshake) begin
      state_next.rts = ~rx_enable_i | rx_buffer_full_i;
    end else if (spi_master) begin
      state_next.rts = (state_next.spi_st == usart_pkg::SPI_IDLE);
    end else begin
      state_next.rts = 1'b0;
    end

    // Ready to take a word; CTS high holds off handshake transmission.
    state_next.tx_ready = tx_enable_i & ~tx_soft_reset_i &
      ~state_next.brk_pend & ~(handshake & cts_s) &
      (spi_mode ? state_next.spi_st == usart_pkg::SPI_IDLE :
       state_next.tx_st == usart_pkg::TX_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  // Lines reset to their idle levels; slave select reads deselected.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
      state_reg.rx_st <= usart_pkg::RX_IDLE;
      state_reg.tx_st <= usart_pkg::TX_IDLE;
      state_reg.spi_st <= usart_pkg::SPI_IDLE;
      state_reg.txd <= `LINE_IDLE;
      state_reg.rts <= `LINE_IDLE;
      state_reg.sck_prev <= `LINE_IDLE;
      state_reg.nss_prev <= `LINE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tx_ready_o = state_reg.tx_ready;
  assign rx_data_o = state_reg.rx_data;
  assign rx_valid_o = state_reg.rx_valid;
  assign rx_break_flag_o = state_reg.rx_break_flag;
  assign frame_error_o = state_reg.frame_error;
  assign txd_o = state_reg.txd;
  assign rts_o = state_reg.rts;
  assign sck_o = state_reg.sck;
  assign sck_oe_o = state_reg.sck_oe;

endmodule // usart_break_handshake_spi_mode

// File: tb/usart_assertions.sv
// Concurrent checks on the ports of the serial transceiver core.
module usart_assertions (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire usart_pkg::usart_cfg_t cfg_i,
  input wire logic rx_enable_i,
  input wire logic rx_buffer_full_i,
  input wire logic clear_status_cmd_i,
  input wire logic tx_valid_i,
  input wire logic cts_i,
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire logic rx_break_flag_o,
  input wire logic frame_error_o,
  input wire logic txd_o,
  input wire logic rts_o,
  input wire logic sck_oe_o
);
  // All checks share the one clock and its synchronous reset.
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  rts_hold_a:
    assert property (cfg_i.mode == 4'h2 && (!rx_enable_i || rx_buffer_full_i)
      |=> rts_o) else $error("RTS not high while receive blocked");
  rts_free_a:
    assert property (cfg_i.mode == 4'h2 && rx_enable_i && !rx_buffer_full_i
      |=> !rts_o) else $error("RTS not low while receive open");
  brk_quiet_a:
    assert property ($rose(rx_break_flag_o) |-> !$rose(frame_error_o)
      && !rx_valid_o) else $error("Break gave a character or error");
  flag_clear_a:
    assert property ($fell(rx_break_flag_o) |-> $past(clear_status_cmd_i))
      else $error("Break flag dropped without clear");
  start_low_a:
    assert property (cfg_i.mode == 4'h0 && tx_ready_o && tx_valid_i
      |=> !txd_o && !tx_ready_o) else $error("No start bit on accept");
  cts_block_a:
    assert property ((cfg_i.mode == 4'h2 && cts_i) [*5] |-> !tx_ready_o)
      else $error("Transmitter ready while CTS high");
  slave_pin_a:
    assert property (cfg_i.mode == 4'hF |=> !sck_oe_o)
      else $error("Slave drives the clock pin");
  spi_select_a:
    assert property (cfg_i.mode == 4'hE && $fell(rts_o) |-> !tx_ready_o)
      else $error("Select dropped outside a character");
endmodule // usart_assertions
bind usart_break_handshake_spi_mode usart_assertions chk (.*);

// File: tb/remote_dev.sv
// Remote serial partner: echoes our TXD back and can hold a break.
module remote_dev (
  input wire logic clock_i,
  input wire logic line_i,
  input wire logic rts_i,
  input wire logic hs_i,
  input wire logic brk_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold = 1'b0;
  // In handshake mode the partner holds no break while its CTS input is high.
  always @(posedge clock_i) begin
    hold <= brk_i && !(hs_i && rts_i);
  end
  // Echo keeps the line driven at all times, so it never floats.
  assign rxd_o = hold ? 1'b0 : line_i;
endmodule // remote_dev

// File: tb/tb_top.sv
// Self-checking bench for the serial transceiver core.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, sys_rst_i = 1, rx_enable_i = 0, tx_enable_i = 0;
  logic rx_soft_reset_i = 0, tx_soft_reset_i = 0, clear_status_cmd_i = 0;
  logic start_break_cmd_i = 0, stop_break_cmd_i = 0, rx_buffer_full_i = 0;
  logic tx_valid_i = 0, cts_i = 0, sck_i = 0, brk = 0, rxd_i;
  logic [8:0] tx_data_i = 9'h000, rx_data_o;
  usart_pkg::usart_cfg_t cfg_i = '0;
  logic tx_ready_o, rx_valid_o, rx_break_flag_o, frame_error_o;
  logic txd_o, rts_o, sck_o, sck_oe_o;
  int failures = 0, n_checks = 0, cyc = 0;
  usart_break_handshake_spi_mode dut (.*);
  remote_dev far (.clock_i(clock_i), .line_i(txd_o), .rts_i(rts_o),
    .hs_i(cfg_i.mode == 4'h2), .brk_i(brk), .rxd_o(rxd_i));
  always #25 clock_i = ~clock_i;
  // The cycle budget of 20000 ends a hung run and counts it as a failure.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Inputs the bench sets after time zero move 5 ns after the rising edge; rxd_i from the partner moves on the edge.
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  // Word and valid stand until an edge sees ready high.
  task automatic send(input logic [8:0] d);
    tx_data_i = d;
    tx_valid_i = 1;
    for (int i = 0; i < 4000 && tx_ready_o !== 1; i++) step(1);
    step(1);
    tx_valid_i = 0;
  endtask
  // Waits for a received word, or for the break flag when f is set.
  task automatic await(input bit f);
    for (int i = 0; i < 4000 && (f ? rx_break_flag_o : rx_valid_o) !== 1;
      i++) step(1);
  endtask
  // Software reset of both halves, owed after every SPI mode change.
  task automatic soft_reset;
    rx_soft_reset_i = 1;
    tx_soft_reset_i = 1;
    step(1);
    rx_soft_reset_i = 0;
    tx_soft_reset_i = 0;
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    cfg_i.clock_divisor = 16'h0001;
    cfg_i.char_length_field = 2'h3;
    step(4);
    sys_rst_i = 0;
    rx_enable_i = 1;
    tx_enable_i = 1;
    step(3);
    send(9'h0A5);
    await(0);
    check(rx_data_o, 9'h0A5);
    check(9'(rx_break_flag_o), 9'h000);
    brk = 1;
    await(1);
    check(9'(frame_error_o), 9'h000);
    check(9'(rx_break_flag_o), 9'h001);
    pulse(clear_status_cmd_i);
    step(1);
    check(9'(rx_break_flag_o), 9'h000);
    brk = 0;
    step(40);
    check(9'(rx_break_flag_o), 9'h001);
    pulse(start_break_cmd_i);
    step(60);
    check(9'(txd_o), 9'h000);
    pulse(stop_break_cmd_i);
    step(1);
    check(9'(txd_o), 9'h001);
    step(60);
    pulse(clear_status_cmd_i);
    cfg_i.mode = 4'h2;
    for (int i = 0; i < 4; i++) begin
      {rx_enable_i, rx_buffer_full_i} = 2'(i);
      step(2);
      check(9'(rts_o), 9'(!rx_enable_i | rx_buffer_full_i));
    end
    rx_buffer_full_i = 0;
    step(2);
    check(9'(rts_o), 9'h000);
    cts_i = 1;
    step(6);
    check(9'(tx_ready_o), 9'h000);
    cts_i = 0;
    step(6);
    check(9'(tx_ready_o), 9'h001);
    send(9'h03C);
    await(0);
    check(rx_data_o, 9'h03C);
    // Master on the undivided clock, clock output on, divisor six.
    cfg_i.mode = 4'hE;
    cfg_i.clock_output_enable = 1;
    cfg_i.clock_divisor = 16'h0006;
    soft_reset();
    step(3);
    send(9'h096);
    check(9'(txd_o), 9'h001);
    check(9'(rts_o), 9'h000);
    check(9'(sck_oe_o), 9'h001);
    check(9'(sck_o), 9'h000);
    // The first rising SCK comes half a divisor after the word is taken.
    step(3);
    check(9'(sck_o), 9'h001);
    await(0);
    check(rx_data_o, 9'h096);
    cfg_i.nine_bit_select = 1;
    step(1);
    send(9'h15A);
    check(9'(txd_o), 9'h001);
    await(0);
    check(rx_data_o, 9'h15A);
    // Slave: deselected while switching, then the bench acts as master.
    cts_i = 1;
    cfg_i.mode = 4'hF;
    soft_reset();
    step(3);
    check(9'(sck_oe_o), 9'h000);
    // The word is offered on the edge that sees the select fall.
    cts_i = 0;
    step(2);
    send(9'h1A6);
    check(9'(txd_o), 9'h001);
    // A sixteen clock SCK period stays well over six clocks per cycle.
    for (int i = 0; i < 9; i++) begin
      sck_i = 1;
      step(8);
      sck_i = 0;
      if (i < 8) step(8);
    end
    await(0);
    check(rx_data_o, 9'h1A6);
    close_out();
  end
endmodule // tb_top
